//--- hdl/control_flow_instruction_unit.sv
`timescale 1ns/100ps
`include "cf_unit_map.svh"
module control_flow_instruction_unit #(
  parameter int STACK_AW = 8
) (
  input  wire logic                    clk_sys,
  input  wire logic                    rst,
  input  wire logic [`CFU_ADDR_W-1:0]  awaddr,
  input  wire logic                    awvalid,
  output logic                         awready,
  input  wire logic [31:0]             wdata,
  input  wire logic [3:0]              wstrb,
  input  wire logic                    wvalid,
  output logic                         wready,
  output logic [1:0]                   bresp,
  output logic                         bvalid,
  input  wire logic                    bready,
  input  wire logic [`CFU_ADDR_W-1:0]  araddr,
  input  wire logic                    arvalid,
  output logic                         arready,
  output logic [31:0]                  rdata,
  output logic [1:0]                   rresp,
  output logic                         rvalid,
  input  wire logic                    rready,
  output logic                         busy
);

  localparam cf_unit_pkg::state_s RST_STATE = '{
    fsm:    cf_unit_pkg::fsm_idle,
    op:     cf_unit_pkg::pointer_branch_op,
    pc:     `CFU_PC_RESET,
    sp:     `CFU_SP_RESET,
    flags:  `CFU_FLAGS_RESET,
    aw_rdy: 1'b1,
    w_rdy:  1'b1,
    ar_rdy: 1'b1,
    default: '0
  };

  cf_unit_pkg::state_s s_reg;
  cf_unit_pkg::state_s s_next;
  logic [7:0]          mem_rdata;
  logic [31:0]         wv;
  logic                wr_fire;
  logic                go;
  cf_unit_pkg::op_e    wr_op;
  cf_unit_pkg::op_e    sel_op;
  logic [15:0]         off_sext;
  logic [15:0]         br_off;
  logic [15:0]         pc_inc;
  logic [15:0]         rel_tgt;
  logic [15:0]         br_tgt;
  logic [15:0]         ret_addr;
  logic [7:0]          ret_lo;
  logic                skip_op;
  logic                skip_cond;
  logic                br_op;
  logic                br_cond;
  logic                invoke_op;
  logic                exit_op;
  logic [2:0]          cycles;
  logic [15:0]         new_pc;
  logic [8:0]          diff;
  logic                cmp_zero;
  logic                half_borrow;

  function automatic logic [31:0] view(input cf_unit_pkg::state_s st, input logic [7:0] a);
    case (a)
      `CFU_CTRL_OFS:  view = {28'h0000000, st.op};
      `CFU_OPND_OFS:  view = {11'h000, st.two, 1'b0, st.bsel, st.opb, st.opa};
      `CFU_PTR_OFS:   view = {16'h0000, st.ptr};
      `CFU_TGT_OFS:   view = {4'h0, st.off, st.abs_tgt};
      `CFU_PC_OFS:    view = {16'h0000, st.pc};
      `CFU_SP_OFS:    view = {16'h0000, st.sp};
      `CFU_FLAGS_OFS: view = {24'h000000, st.flags};
      `CFU_STAT_OFS:  view = {20'h00000, 1'b0, st.last_cyc, 7'h00, st.busy};
      default:        view = 32'h00000000;
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'h0) && (a <= `CFU_STAT_OFS);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] b);
    logic [31:0] m;
    m = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
    merge = (o & ~m) | (d & m);
  endfunction

  stack_mem #(
    .AW (STACK_AW)
  ) u_stack (
    .clk_sys (clk_sys),
    .rst     (rst),
    .req     (s_reg.mreq),
    .rdata   (mem_rdata)
  );

  assign wv       = merge(view(s_reg, s_reg.awaddr), s_reg.wdata, s_reg.wstrb);
  assign wr_fire  = !s_reg.aw_rdy && !s_reg.w_rdy && !s_reg.bvalid;
  assign wr_op    = cf_unit_pkg::op_e'(wv[3:0]);
  assign go       = wr_fire && (s_reg.awaddr == `CFU_CTRL_OFS) && wv[`CFU_CTRL_START_BIT]
                    && !s_reg.busy;
  assign sel_op   = (s_reg.fsm == cf_unit_pkg::fsm_idle) ? wr_op : s_reg.op;
  assign off_sext = {{4{s_reg.off[11]}}, s_reg.off};
  assign br_off   = {{9{s_reg.off[6]}}, s_reg.off[6:0]};
  assign pc_inc   = s_reg.pc + 16'h0001;
  assign rel_tgt  = pc_inc + off_sext;
  assign br_tgt   = pc_inc + br_off;
  assign ret_lo   = ret_addr[7:0];
  assign diff     = {1'b0, s_reg.opa} - {1'b0, s_reg.opb};
  assign cmp_zero = (diff[7:0] == 8'h00);
  assign half_borrow = (~s_reg.opa[3] & s_reg.opb[3]) | (s_reg.opb[3] & diff[3])
                       | (diff[3] & ~s_reg.opa[3]);

  // return point is the word after the invoking instruction
  always_comb
  begin
    if (sel_op == cf_unit_pkg::direct_far_invoke_op)
    begin
      ret_addr = s_reg.pc + 16'h0002;
    end
    else
    begin
      ret_addr = pc_inc;
    end
  end

  always_comb
  begin
    skip_op   = 1'b1;
    skip_cond = 1'b0;
    br_op     = 1'b0;
    br_cond   = 1'b0;
    invoke_op = 1'b0;
    exit_op   = 1'b0;
    case (sel_op)
      cf_unit_pkg::equal_skip_op:         skip_cond = (s_reg.opa == s_reg.opb);
      cf_unit_pkg::skip_reg_bit_clear_op: skip_cond = ~s_reg.opa[s_reg.bsel];
      cf_unit_pkg::skip_reg_bit_set_op:   skip_cond = s_reg.opa[s_reg.bsel];
      cf_unit_pkg::skip_io_bit_clear_op:  skip_cond = ~s_reg.opb[s_reg.bsel];
      cf_unit_pkg::skip_io_bit_set_op:    skip_cond = s_reg.opb[s_reg.bsel];
      default:                            skip_op = 1'b0;
    endcase
    case (sel_op)
      cf_unit_pkg::branch_flag_set_op:
      begin
        br_op   = 1'b1;
        br_cond = s_reg.flags[s_reg.bsel];
      end
      cf_unit_pkg::branch_flag_clear_op:
      begin
        br_op   = 1'b1;
        br_cond = ~s_reg.flags[s_reg.bsel];
      end
      cf_unit_pkg::relative_invoke_op,
      cf_unit_pkg::pointer_invoke_op,
      cf_unit_pkg::direct_far_invoke_op:  invoke_op = 1'b1;
      cf_unit_pkg::subroutine_exit_op,
      cf_unit_pkg::interrupt_exit_op:     exit_op = 1'b1;
      default:                            br_op = 1'b0;
    endcase
  end

  always_comb
  begin
    cycles = `CFU_CYC_SEQ;
    new_pc = pc_inc;
    case (sel_op)
      cf_unit_pkg::pointer_branch_op:
      begin
        cycles = `CFU_CYC_PTR_BRANCH;
        new_pc = s_reg.ptr;
      end
      cf_unit_pkg::direct_far_branch_op:
      begin
        cycles = `CFU_CYC_FAR_BRANCH;
        new_pc = s_reg.abs_tgt;
      end
      cf_unit_pkg::relative_invoke_op:
      begin
        cycles = `CFU_CYC_REL_INVOKE;
        new_pc = rel_tgt;
      end
      cf_unit_pkg::pointer_invoke_op:
      begin
        cycles = `CFU_CYC_PTR_INVOKE;
        new_pc = s_reg.ptr;
      end
      cf_unit_pkg::direct_far_invoke_op:
      begin
        cycles = `CFU_CYC_FAR_INVOKE;
        new_pc = s_reg.abs_tgt;
      end
      cf_unit_pkg::subroutine_exit_op,
      cf_unit_pkg::interrupt_exit_op:
      begin
        cycles = `CFU_CYC_EXIT;
        new_pc = {s_reg.hi, s_reg.lo};
      end
      default:
      begin
        if (skip_op && skip_cond && s_reg.two)
        begin
          cycles = `CFU_CYC_SKIP_TWO;
          new_pc = s_reg.pc + 16'h0003;
        end
        else if (skip_op && skip_cond)
        begin
          cycles = `CFU_CYC_SKIP_ONE;
          new_pc = s_reg.pc + 16'h0002;
        end
        else if (br_op && br_cond)
        begin
          cycles = `CFU_CYC_TAKEN;
          new_pc = br_tgt;
        end
      end
    endcase
  end

  always_comb
  begin
    s_next         = s_reg;
    s_next.mreq.we = 1'b0;
    if (awvalid && s_reg.aw_rdy)
    begin
      s_next.aw_rdy = 1'b0;
      s_next.awaddr = awaddr;
    end
    if (wvalid && s_reg.w_rdy)
    begin
      s_next.w_rdy = 1'b0;
      s_next.wdata = wdata;
      s_next.wstrb = wstrb;
    end
    if (s_reg.bvalid && bready)
    begin
      s_next.bvalid = 1'b0;
    end
    if (wr_fire)
    begin
      s_next.bvalid = 1'b1;
      s_next.aw_rdy = 1'b1;
      s_next.w_rdy  = 1'b1;
      s_next.bresp  = mapped(s_reg.awaddr) ? `CFU_RESP_OKAY : `CFU_RESP_SLVERR;
      // writes are dropped while an instruction runs
      if (!s_reg.busy)
      begin
        case (s_reg.awaddr)
          `CFU_CTRL_OFS:  s_next.op = wr_op;
          `CFU_OPND_OFS:
          begin
            s_next.opa  = wv[7:0];
            s_next.opb  = wv[`CFU_OPND_B_LSB +: 8];
            s_next.bsel = wv[`CFU_OPND_SEL_LSB +: 3];
            s_next.two  = wv[`CFU_OPND_TWO_BIT];
          end
          `CFU_PTR_OFS:   s_next.ptr = wv[15:0];
          `CFU_TGT_OFS:
          begin
            s_next.abs_tgt = wv[15:0];
            s_next.off     = wv[`CFU_TGT_OFF_LSB +: 12];
          end
          `CFU_PC_OFS:    s_next.pc = wv[15:0];
          `CFU_SP_OFS:    s_next.sp = wv[15:0];
          `CFU_FLAGS_OFS: s_next.flags = wv[7:0];
          default:        s_next.op = s_reg.op;
        endcase
      end
    end
    if (s_reg.rvalid && rready)
    begin
      s_next.rvalid = 1'b0;
      s_next.ar_rdy = 1'b1;
    end
    if (arvalid && s_reg.ar_rdy)
    begin
      s_next.ar_rdy = 1'b0;
      s_next.rvalid = 1'b1;
      s_next.rdata  = view(s_reg, araddr);
      s_next.rresp  = mapped(araddr) ? `CFU_RESP_OKAY : `CFU_RESP_SLVERR;
    end
    case (s_reg.fsm)
      cf_unit_pkg::fsm_idle:
      begin
        if (go)
        begin
          s_next.fsm   = cf_unit_pkg::fsm_exec;
          s_next.busy  = 1'b1;
          s_next.cnt   = 3'h1;
          s_next.total = cycles;
          // stack read data lag the address by one cycle, so start early
          if (exit_op)
          begin
            s_next.mreq.raddr = s_reg.sp + 16'h0001;
          end
        end
      end
      cf_unit_pkg::fsm_exec:
      begin
        s_next.cnt = s_reg.cnt + 3'h1;
        // push low byte first, high byte below it
        if (invoke_op && (s_reg.cnt <= 3'h2))
        begin
          s_next.mreq.we    = 1'b1;
          s_next.mreq.waddr = s_reg.sp;
          s_next.mreq.wdata = (s_reg.cnt == 3'h1) ? ret_addr[7:0] : ret_addr[15:8];
          s_next.sp         = s_reg.sp - 16'h0001;
        end
        if (exit_op)
        begin
          if (s_reg.cnt == 3'h1)
          begin
            s_next.mreq.raddr = s_reg.sp + 16'h0002;
          end
          if (s_reg.cnt == 3'h2)
          begin
            s_next.hi = mem_rdata;
          end
          if (s_reg.cnt == 3'h3)
          begin
            s_next.lo = mem_rdata;
          end
        end
        if (s_reg.cnt == s_reg.total)
        begin
          s_next.fsm      = cf_unit_pkg::fsm_idle;
          s_next.busy     = 1'b0;
          s_next.last_cyc = s_reg.total;
          s_next.pc       = new_pc;
          if (exit_op)
          begin
            s_next.sp = s_reg.sp + 16'h0002;
          end
          if (s_reg.op == cf_unit_pkg::interrupt_exit_op)
          begin
            s_next.flags[`CFU_FLAG_I] = 1'b1;
          end
          if (s_reg.op == cf_unit_pkg::immediate_compare_op)
          begin
            s_next.flags[`CFU_FLAG_Z] = cmp_zero;
            s_next.flags[`CFU_FLAG_N] = diff[7];
            s_next.flags[`CFU_FLAG_C] = diff[8];
            s_next.flags[`CFU_FLAG_H] = half_borrow;
            s_next.flags[`CFU_FLAG_V] = (s_reg.opa[7] & ~s_reg.opb[7] & ~diff[7])
                                        | (~s_reg.opa[7] & s_reg.opb[7] & diff[7]);
          end
        end
      end
      default: s_next.fsm = cf_unit_pkg::fsm_idle;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      s_reg <= RST_STATE;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign awready = s_reg.aw_rdy;
  assign wready  = s_reg.w_rdy;
  assign bvalid  = s_reg.bvalid;
  assign bresp   = s_reg.bresp;
  assign arready = s_reg.ar_rdy;
  assign rvalid  = s_reg.rvalid;
  assign rdata   = s_reg.rdata;
  assign rresp   = s_reg.rresp;
  assign busy    = s_reg.busy;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence run1_s; s_reg.busy [*1]; endsequence
  sequence run2_s; s_reg.busy [*2]; endsequence
  sequence run3_s; s_reg.busy [*3]; endsequence
  sequence run4_s; s_reg.busy [*4]; endsequence

  ptr_branch_a: assert property (go && wr_op == cf_unit_pkg::pointer_branch_op |=>
    run2_s ##1 (!s_reg.busy && s_reg.pc == $past(s_reg.ptr, 3)
    && s_reg.flags == $past(s_reg.flags, 3))) else $error("pointer branch wrong");
  ptr_invoke_a: assert property (go && wr_op == cf_unit_pkg::pointer_invoke_op |=>
    run3_s ##1 (!s_reg.busy && s_reg.pc == $past(s_reg.ptr, 4)
    && s_reg.sp == $past(s_reg.sp, 4) - 16'h0002)) else $error("pointer invoke wrong");
  rel_invoke_a: assert property (go && wr_op == cf_unit_pkg::relative_invoke_op |=>
    run3_s ##1 (!s_reg.busy && s_reg.pc == $past(s_reg.pc, 4) + 16'h0001
    + {{4{$past(s_reg.off[11], 4)}}, $past(s_reg.off, 4)}))
    else $error("relative invoke wrong");
  far_invoke_a: assert property (go && wr_op == cf_unit_pkg::direct_far_invoke_op |=>
    run4_s ##1 (!s_reg.busy && s_reg.pc == $past(s_reg.abs_tgt, 5)))
    else $error("far invoke wrong");
  sub_exit_a: assert property (go && wr_op == cf_unit_pkg::subroutine_exit_op |=>
    run4_s ##1 (!s_reg.busy && s_reg.sp == $past(s_reg.sp, 5) + 16'h0002
    && s_reg.flags == $past(s_reg.flags, 5))) else $error("subroutine exit wrong");
  int_exit_a: assert property (go && wr_op == cf_unit_pkg::interrupt_exit_op |=>
    run4_s ##1 (!s_reg.busy && s_reg.flags[`CFU_FLAG_I])) else $error("interrupt exit wrong");
  push_ret_a: assert property (go && invoke_op |=> ##1
    (s_reg.mreq.we && s_reg.mreq.wdata == $past(ret_lo, 2))) else $error("return push wrong");
  equal_skip_a: assert property (go && wr_op == cf_unit_pkg::equal_skip_op
    && s_reg.opa == s_reg.opb && !s_reg.two |=> run2_s ##1
    (s_reg.pc == $past(s_reg.pc, 3) + 16'h0002 && s_reg.flags == $past(s_reg.flags, 3)))
    else $error("equal skip wrong");
  imm_cmp_a: assert property (go && wr_op == cf_unit_pkg::immediate_compare_op |=>
    run1_s ##1 (!s_reg.busy
    && s_reg.flags[`CFU_FLAG_Z] == ($past(s_reg.opa, 2) == $past(s_reg.opb, 2))
    && s_reg.pc == $past(s_reg.pc, 2) + 16'h0001)) else $error("immediate compare wrong");
  no_skip_a: assert property (go && skip_op && !skip_cond |=>
    run1_s ##1 (!s_reg.busy && s_reg.pc == $past(pc_inc, 2)))
    else $error("no-skip path wrong");
  skip_two_a: assert property (go && skip_op && skip_cond && s_reg.two |=>
    run3_s ##1 (!s_reg.busy && s_reg.pc == $past(s_reg.pc, 4) + 16'h0003))
    else $error("two-word skip wrong");
  br_taken_a: assert property (go && br_op && br_cond |=>
    run2_s ##1 (!s_reg.busy && s_reg.pc == $past(s_reg.pc, 3) + 16'h0001
    + {{9{$past(s_reg.off[6], 3)}}, $past(s_reg.off[6:0], 3)}))
    else $error("branch taken wrong");
  br_fall_a: assert property (go && br_op && !br_cond |=>
    run1_s ##1 (!s_reg.busy && s_reg.pc == $past(pc_inc, 2))) else $error("fall-through wrong");

endmodule // control_flow_instruction_unit

//--- shared/cf_unit_map.svh
`ifndef CF_UNIT_MAP_SVH
`define CF_UNIT_MAP_SVH

`define CFU_ADDR_W         8
`define CFU_CTRL_OFS       8'h00
`define CFU_OPND_OFS       8'h04
`define CFU_PTR_OFS        8'h08
`define CFU_TGT_OFS        8'h0C
`define CFU_PC_OFS         8'h10
`define CFU_SP_OFS         8'h14
`define CFU_FLAGS_OFS      8'h18
`define CFU_STAT_OFS       8'h1C

`define CFU_CTRL_START_BIT 8
`define CFU_OPND_B_LSB     8
`define CFU_OPND_SEL_LSB   16
`define CFU_OPND_TWO_BIT   20
`define CFU_TGT_OFF_LSB    16

`define CFU_FLAG_C         0
`define CFU_FLAG_Z         1
`define CFU_FLAG_N         2
`define CFU_FLAG_V         3
`define CFU_FLAG_H         5
`define CFU_FLAG_I         7

`define CFU_PC_RESET       16'h0000
`define CFU_SP_RESET       16'h00FF
`define CFU_FLAGS_RESET    8'h00

`define CFU_CYC_SEQ        3'h1
`define CFU_CYC_PTR_BRANCH 3'h2
`define CFU_CYC_FAR_BRANCH 3'h3
`define CFU_CYC_PTR_INVOKE 3'h3
`define CFU_CYC_REL_INVOKE 3'h3
`define CFU_CYC_FAR_INVOKE 3'h4
`define CFU_CYC_EXIT       3'h4
`define CFU_CYC_TAKEN      3'h2
`define CFU_CYC_SKIP_ONE   3'h2
`define CFU_CYC_SKIP_TWO   3'h3

`define CFU_RESP_OKAY      2'h0
`define CFU_RESP_SLVERR    2'h2

`endif

//--- shared/cf_unit_pkg.sv
package cf_unit_pkg;

  typedef enum logic [3:0] {
    pointer_branch_op,
    direct_far_branch_op,
    relative_invoke_op,
    pointer_invoke_op,
    direct_far_invoke_op,
    subroutine_exit_op,
    interrupt_exit_op,
    equal_skip_op,
    immediate_compare_op,
    skip_reg_bit_clear_op,
    skip_reg_bit_set_op,
    skip_io_bit_clear_op,
    skip_io_bit_set_op,
    branch_flag_set_op,
    branch_flag_clear_op
  } op_e;

  typedef enum logic [0:0] {
    fsm_idle,
    fsm_exec
  } fsm_e;

  typedef struct packed {
    logic        we;
    logic [15:0] waddr;
    logic [7:0]  wdata;
    logic [15:0] raddr;
  } stack_req_s;

  typedef struct packed {
    fsm_e        fsm;
    logic        busy;
    logic [2:0]  cnt;
    logic [2:0]  total;
    logic [2:0]  last_cyc;
    op_e         op;
    logic [15:0] pc;
    logic [15:0] sp;
    logic [15:0] ptr;
    logic [15:0] abs_tgt;
    logic [11:0] off;
    logic [7:0]  flags;
    logic [7:0]  opa;
    logic [7:0]  opb;
    logic [7:0]  hi;
    logic [7:0]  lo;
    logic [2:0]  bsel;
    logic        two;
    logic        aw_rdy;
    logic        w_rdy;
    logic        bvalid;
    logic        ar_rdy;
    logic        rvalid;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic [31:0] rdata;
    logic [1:0]  bresp;
    logic [1:0]  rresp;
    stack_req_s  mreq;
  } state_s;

endpackage

//--- hdl/stack_mem.sv
`timescale 1ns/100ps
module stack_mem #(
  parameter int AW = 8
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire cf_unit_pkg::stack_req_s req,
  output logic [7:0]                  rdata
);

  logic [7:0] mem [0:(1<<AW)-1];
  logic [7:0] rdata_reg;

  always_ff @(posedge clk_sys)
  begin
    if (req.we)
    begin
      mem[req.waddr[AW-1:0]] <= req.wdata;
    end
  end

  // read data are registered: valid one cycle after the address
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rdata_reg <= 8'h00;
    end
    else
    begin
      rdata_reg <= mem[req.raddr[AW-1:0]];
    end
  end

  assign rdata = rdata_reg;

endmodule // stack_mem

//--- verification/tb_control_flow_instruction_unit.sv
`timescale 1ns/100ps
`include "cf_unit_map.svh"
module tb_control_flow_instruction_unit;
  typedef struct packed {
    logic [3:0]  op;
    logic [31:0] opnd;
    logic [31:0] tgt;
    logic [7:0]  fl;
    logic [15:0] epc;
    logic [7:0]  efl;
    logic [2:0]  ecyc;
  } row_s;
  logic        clk_sys, rst, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic        awready, wready, bvalid, arready, rvalid, busy;
  logic [1:0]  bresp, rresp, wrsp, rrsp;
  int          n_mismatch, num_checks;
  row_s        rows [24];

  control_flow_instruction_unit uut (.clk_sys(clk_sys), .rst(rst), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .busy(busy));

  initial
  begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    @(posedge clk_sys);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    hb = 1'b0;
    while (!hb)
    begin
      @(negedge clk_sys);
      ha = awvalid & awready;
      hw = wvalid & wready;
      hb = (bvalid === 1'b1);
      wrsp = bresp;
      @(posedge clk_sys);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
      if (hb) bready <= 1'b0;
    end
  endtask

  task automatic axr(input logic [7:0] a);
    logic ha, hr;
    @(posedge clk_sys);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    hr = 1'b0;
    while (!hr)
    begin
      @(negedge clk_sys);
      ha = arvalid & arready;
      hr = (rvalid === 1'b1);
      rd = rdata;
      rrsp = rresp;
      @(posedge clk_sys);
      if (ha) arvalid <= 1'b0;
      if (hr) rready <= 1'b0;
    end
  endtask

  task automatic load(input logic [15:0] pc, input logic [7:0] fl, input logic [31:0] opnd,
                      input logic [31:0] tgt);
    axw(`CFU_PC_OFS, {16'h0000, pc});
    axw(`CFU_SP_OFS, 32'h0000_00FF);
    axw(`CFU_FLAGS_OFS, {24'h0, fl});
    axw(`CFU_OPND_OFS, opnd);
    axw(`CFU_PTR_OFS, 32'h0000_1234);
    axw(`CFU_TGT_OFS, tgt);
  endtask

  task automatic run(input logic [3:0] op);
    axw(`CFU_CTRL_OFS, {23'h0, 1'b1, 4'h0, op});
    @(negedge clk_sys);
    while (busy !== 1'b0) @(negedge clk_sys);
  endtask

  task automatic expect_state(input logic [15:0] pc, input logic [15:0] sp,
                              input logic [7:0] fl, input logic [2:0] cyc);
    axr(`CFU_PC_OFS);
    chk(rd, {16'h0, pc});
    axr(`CFU_SP_OFS);
    chk(rd, {16'h0, sp});
    axr(`CFU_FLAGS_OFS);
    chk(rd, {24'h0, fl});
    axr(`CFU_STAT_OFS);
    chk(rd, {21'h0, cyc, 8'h00});
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    summarize();
  end

  initial
  begin
    rows[0]  = '{4'h0, 32'h0, 32'h0FFE_2000, 8'h3C, 16'h1234, 8'h3C, 3'h2};
    rows[1]  = '{4'h3, 32'h0, 32'h0FFE_2000, 8'h3C, 16'h1234, 8'h3C, 3'h3};
    rows[2]  = '{4'h2, 32'h0, 32'h0FFE_2000, 8'h3C, 16'h00FF, 8'h3C, 3'h3};
    rows[3]  = '{4'h4, 32'h0, 32'h0FFE_2000, 8'h3C, 16'h2000, 8'h3C, 3'h4};
    rows[4]  = '{4'h1, 32'h0, 32'h0FFE_3000, 8'h00, 16'h3000, 8'h00, 3'h3};
    rows[5]  = '{4'h7, 32'h0000_5555, 32'h0, 8'hA1, 16'h0102, 8'hA1, 3'h2};
    rows[6]  = '{4'h7, 32'h0010_5455, 32'h0, 8'h00, 16'h0101, 8'h00, 3'h1};
    rows[7]  = '{4'h7, 32'h0010_5555, 32'h0, 8'h00, 16'h0103, 8'h00, 3'h3};
    rows[8]  = '{4'h8, 32'h0000_2010, 32'h0, 8'h80, 16'h0101, 8'h85, 3'h1};
    rows[9]  = '{4'h8, 32'h0000_0180, 32'h0, 8'h80, 16'h0101, 8'hA8, 3'h1};
    rows[10] = '{4'h8, 32'h0000_3333, 32'h0, 8'h50, 16'h0101, 8'h52, 3'h1};
    rows[11] = '{4'h9, 32'h0002_00FB, 32'h0, 8'hA1, 16'h0102, 8'hA1, 3'h2};
    rows[12] = '{4'h9, 32'h0002_0004, 32'h0, 8'h00, 16'h0101, 8'h00, 3'h1};
    rows[13] = '{4'hA, 32'h0017_0080, 32'h0, 8'h00, 16'h0103, 8'h00, 3'h3};
    rows[14] = '{4'hA, 32'h0007_007F, 32'h0, 8'h00, 16'h0101, 8'h00, 3'h1};
    rows[15] = '{4'hB, 32'h0000_0100, 32'h0, 8'h00, 16'h0101, 8'h00, 3'h1};
    rows[16] = '{4'hB, 32'h0000_FE00, 32'h0, 8'hA1, 16'h0102, 8'hA1, 3'h2};
    rows[17] = '{4'hC, 32'h0000_0100, 32'h0, 8'h00, 16'h0102, 8'h00, 3'h2};
    rows[18] = '{4'hC, 32'h0010_FE00, 32'h0, 8'h00, 16'h0101, 8'h00, 3'h1};
    rows[19] = '{4'hD, 32'h0001_0000, 32'h0005_0000, 8'h02, 16'h0106, 8'h02, 3'h2};
    rows[20] = '{4'hD, 32'h0000_0000, 32'h0005_0000, 8'h02, 16'h0101, 8'h02, 3'h1};
    rows[21] = '{4'hE, 32'h0001_0000, 32'h007D_0000, 8'h02, 16'h0101, 8'h02, 3'h1};
    rows[22] = '{4'hE, 32'h0000_0000, 32'h007D_0000, 8'h02, 16'h00FE, 8'h02, 3'h2};
    rows[23] = '{4'hF, 32'h0, 32'h0, 8'h00, 16'h0101, 8'h00, 3'h1};
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = {8'h00, 8'h00, 32'h0, 4'hF};
    n_mismatch = 0;
    num_checks = 0;
    rst = 1'b1;
    repeat (10) @(posedge clk_sys);
    rst <= 1'b0;
    expect_state(16'h0000, 16'h00FF, 8'h00, 3'h0);
    $display("reset test done");
    foreach (rows[i])
    begin
      load(16'h0100, rows[i].fl, rows[i].opnd, rows[i].tgt);
      run(rows[i].op);
      expect_state(rows[i].epc, (rows[i].op inside {4'h2, 4'h3, 4'h4}) ? 16'h00FD : 16'h00FF,
                   rows[i].efl, rows[i].ecyc);
      $display("row %0d done", i);
    end
    // call then return, stack left in place between them
    // far invoke; a flags write while it runs must be dropped
    load(16'h0100, 8'h3C, 32'h0, 32'h0000_2000);
    axw(`CFU_CTRL_OFS, 32'h0000_0104);
    @(negedge clk_sys);
    chk({31'h0, busy}, 32'h0000_0001);
    axw(`CFU_FLAGS_OFS, 32'h0000_0000);
    run(4'h5);
    expect_state(16'h0102, 16'h00FF, 8'h3C, 3'h4);
    load(16'h0200, 8'h01, 32'h0, 32'h0000_0000);
    run(4'h2);
    run(4'h6);
    expect_state(16'h0201, 16'h00FF, 8'h81, 3'h4);
    $display("return test done");
    axr(8'h20);
    chk(rd, 32'h0000_0000);
    chk({30'h0, rrsp}, {30'h0, `CFU_RESP_SLVERR});
    axw(8'h20, 32'h0000_FFFF);
    chk({30'h0, wrsp}, {30'h0, `CFU_RESP_SLVERR});
    $display("unmapped test done");
    summarize();
  end
endmodule // tb_control_flow_instruction_unit
